/* File: hw/erb_map.vh */
`ifndef ERB_MAP_VH
`define ERB_MAP_VH

// Block variants
`define ERB_VAR_SMALL 0
`define ERB_VAR_MEDIUM 1
`define ERB_VAR_LARGE 2

// Port modes
`define ERB_MODE_TDP 0
`define ERB_MODE_SDP 1
`define ERB_MODE_SP 2
`define ERB_MODE_ROM 3
`define ERB_MODE_SPLIT 4

// Capacities in bits, parity included
`define ERB_SMALL_BITS 576
`define ERB_MEDIUM_BITS 4608

// Native shape of the large variant
`define ERB_LARGE_DEPTH 4096
`define ERB_LARGE_WIDTH 144

// Default unit width: one byte plus its parity bit
`define ERB_UNIT_W 9
`define ERB_DEPTH 512

`endif

/* File: hw/erb_ram.v */
`timescale 1ns/1ns
`include "erb_map.vh"

module erb_ram #(
    parameter VARIANT = `ERB_VAR_MEDIUM,
    parameter MODE = `ERB_MODE_TDP,
    parameter UNIT_W = `ERB_UNIT_W,
    parameter DEPTH = `ERB_DEPTH,
    parameter RA = 1,
    parameter RB = 1,
    parameter OUT_REG = 1,
    parameter FLOW = 0
) (
    // Clock and reset
    input wire mclk,
    input wire rst_n,
    // Asynchronous clears
    input wire in_clr_n,
    input wire out_clr_n,
    // Port A
    input wire [erb_clog2(DEPTH/RA)-1:0] a_addr,
    input wire [UNIT_W*RA-1:0] a_din,
    input wire a_we,
    input wire a_re,
    output wire [UNIT_W*RA-1:0] a_dout,
    // Port B
    input wire [erb_clog2(DEPTH/RB)-1:0] b_addr,
    input wire [UNIT_W*RB-1:0] b_din,
    input wire b_we,
    input wire b_re,
    output wire [UNIT_W*RB-1:0] b_dout
);

    // Address width of a port holding n words
    function integer erb_clog2;
        input integer n;
        integer v;
        begin
            v = n - 1;
            erb_clog2 = 0;
            while (v > 0) begin
                erb_clog2 = erb_clog2 + 1;
                v = v >> 1;
            end
            if (erb_clog2 == 0)
                erb_clog2 = 1;
        end
    endfunction

    // Derived widths and per-port capabilities; refused operations are masked at capture
    localparam AW_A = erb_clog2(DEPTH/RA);
    localparam AW_B = erb_clog2(DEPTH/RB);
    localparam WA = UNIT_W * RA;
    localparam WB = UNIT_W * RB;
    localparam IS_SMALL = (VARIANT == `ERB_VAR_SMALL);
    localparam IS_LARGE = (VARIANT == `ERB_VAR_LARGE);
    // Small has no true dual-port; large ROM is emulated through dual-port writes
    localparam TDP_EFF = !IS_SMALL && ((MODE == `ERB_MODE_TDP) ||
                         (MODE == `ERB_MODE_ROM && IS_LARGE));
    localparam SDP_EFF = (MODE == `ERB_MODE_SDP) || (MODE == `ERB_MODE_TDP && IS_SMALL);
    localparam SPLIT = (MODE == `ERB_MODE_SPLIT) && (VARIANT == `ERB_VAR_MEDIUM);
    localparam A_WR = (MODE != `ERB_MODE_ROM) || IS_LARGE;
    localparam A_RD = !SDP_EFF;
    localparam B_WR = TDP_EFF || SPLIT;
    localparam B_RD = TDP_EFF || SDP_EFF || SPLIT || (MODE == `ERB_MODE_ROM);
    localparam B_FLOW = FLOW && SDP_EFF && !IS_LARGE;
    localparam HALF = DEPTH / 2;

    // Storage in units of one byte plus parity; wide ports span several units
    reg [UNIT_W-1:0] mem [0:DEPTH-1];

    ////////////////////////////////////////////////////////////////////////////
    // Input registers

    // Large variant ignores the input clear
    wire in_rst_n = rst_n & (in_clr_n | IS_LARGE[0]);
    wire out_rst_n = rst_n & out_clr_n;

    // Captured request, one set per port
    reg [AW_A-1:0] a_addr_q;
    reg [WA-1:0] a_din_q;
    reg a_we_q;
    reg a_re_q;
    reg [AW_B-1:0] b_addr_q;
    reg [WB-1:0] b_din_q;
    reg b_we_q;
    reg b_re_q;
    reg [AW_B-1:0] b_raddr_nq;
    reg b_re_nq;

    // Clear acts on these at once; registered outputs keep their value, as the cleared read enables stop their load
    always @(posedge mclk or negedge in_rst_n) begin
        if (!in_rst_n) begin
            a_addr_q <= {AW_A{1'b0}};
            a_din_q <= {WA{1'b0}};
            a_we_q <= 1'b0;
            a_re_q <= 1'b0;
            b_addr_q <= {AW_B{1'b0}};
            b_din_q <= {WB{1'b0}};
            b_we_q <= 1'b0;
            b_re_q <= 1'b0;
        end else begin
            a_addr_q <= a_addr;
            a_din_q <= a_din;
            a_we_q <= a_we & A_WR[0];
            // Single-port reads and writes are exclusive; a write wins
            a_re_q <= a_re & A_RD[0] & ~(a_we & A_WR[0]);
            b_addr_q <= b_addr;
            b_din_q <= b_din;
            b_we_q <= b_we & B_WR[0];
            b_re_q <= b_re & B_RD[0] & ~(b_we & B_WR[0]);
        end
    end

    // Flow-through read address stage on the falling edge
    always @(negedge mclk or negedge in_rst_n) begin
        if (!in_rst_n) begin
            b_raddr_nq <= {AW_B{1'b0}};
            b_re_nq <= 1'b0;
        end else begin
            b_raddr_nq <= b_addr;
            b_re_nq <= b_re & B_RD[0];
        end
    end

    // Flow-through swaps in the falling-edge address; this halves its setup window
    wire [AW_B-1:0] b_raddr = B_FLOW ? b_raddr_nq : b_addr_q;
    wire b_rd = B_FLOW ? b_re_nq : b_re_q;

    ////////////////////////////////////////////////////////////////////////////
    // Unit index of each port; split mode confines A to low half, B to high

    reg [31:0] a_idx;
    reg [31:0] b_idx;
    reg [31:0] b_ridx;
    always @* begin
        a_idx = a_addr_q * RA;
        b_idx = b_addr_q * RB;
        b_ridx = b_raddr * RB;
        if (SPLIT) begin
            a_idx = a_idx % HALF;
            b_idx = HALF + (b_idx % HALF);
            b_ridx = HALF + (b_ridx % HALF);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Array write, strobed by the registered enable one edge after capture

    integer i;
    always @(posedge mclk) begin
        for (i = 0; i < RA; i = i + 1) begin
            if (a_we_q)
                mem[a_idx + i] <= a_din_q[i*UNIT_W +: UNIT_W];
        end
        // Port B is applied last; same-address collisions are undefined anyway
        for (i = 0; i < RB; i = i + 1) begin
            if (b_we_q)
                mem[b_idx + i] <= b_din_q[i*UNIT_W +: UNIT_W];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Array read; a read beside a write in the same cycle sees the old word, except on port B of the large variant

    // Read words assembled unit by unit, lowest unit in the low bits
    reg [WA-1:0] a_rd_d;
    reg [WB-1:0] b_rd_d;
    reg b_clash;
    integer k;
    always @* begin
        a_rd_d = {WA{1'b0}};
        b_rd_d = {WB{1'b0}};
        for (k = 0; k < RA; k = k + 1)
            a_rd_d[k*UNIT_W +: UNIT_W] = mem[a_idx + k];
        for (k = 0; k < RB; k = k + 1)
            b_rd_d[k*UNIT_W +: UNIT_W] = mem[b_ridx + k];
        b_clash = a_we_q && (a_idx < b_ridx + RB) && (b_ridx < a_idx + RA);
        // Large variant gives no old-data guarantee on a mixed-port clash
        if (IS_LARGE && b_clash)
            b_rd_d = {WB{1'bx}};
    end

    ////////////////////////////////////////////////////////////////////////////
    // Output registers, cleared immediately by their own clear

    reg [WA-1:0] a_dout_q;
    reg [WB-1:0] b_dout_q;
    always @(posedge mclk or negedge out_rst_n) begin
        if (!out_rst_n) begin
            a_dout_q <= {WA{1'b0}};
            b_dout_q <= {WB{1'b0}};
        end else begin
            if (a_re_q)
                a_dout_q <= a_rd_d;
            if (b_rd)
                b_dout_q <= b_rd_d;
        end
    end

    // Bypass trades a cycle of latency for a longer combinational path
    assign a_dout = (OUT_REG != 0) ? a_dout_q : a_rd_d;
    assign b_dout = (OUT_REG != 0 && !B_FLOW) ? b_dout_q : b_rd_d;

endmodule // erb_ram

/* File: testbench/erb_ram_checker.sv */
`timescale 1ns/1ns
module erb_chk #(
    // Zero where the bound copy bypasses its outputs; the shadow is registered only
    parameter LIVE = 1
) (
    // Clock, reset, clears
    input wire mclk, rst_n, in_clr_n, out_clr_n,
    // Port A, one unit
    input wire [8:0] a_addr, a_din, a_dout,
    input wire a_we, a_re,
    // Port B, two units
    input wire [7:0] b_addr,
    input wire [17:0] b_din, b_dout,
    input wire b_we, b_re
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!LIVE || !rst_n || !in_clr_n || !out_clr_n);
    reg [8:0] m [0:511];
    reg [8:0] ea_q;
    reg [17:0] eb_q;
    // Shadow array; B last so it wins a same-unit clash
    always @(posedge mclk) begin
        if (a_we) m[a_addr] <= a_din;
        if (b_we) m[{b_addr, 1'b0}] <= b_din[8:0];
        if (b_we) m[{b_addr, 1'b1}] <= b_din[17:9];
        ea_q <= m[a_addr];
        eb_q <= {m[{b_addr, 1'b1}], m[{b_addr, 1'b0}]};
    end
    a_clr_a: assert property (disable iff (!LIVE || !rst_n) !out_clr_n |-> a_dout == 9'h0)
        else $error("a not cleared");
    b_clr_a: assert property (disable iff (!LIVE || !rst_n) !out_clr_n |-> b_dout == 18'h0)
        else $error("b not cleared");
    a_hold_a: assert property (!a_re || a_we |=> ##1 $stable(a_dout))
        else $error("a moved");
    b_hold_a: assert property (!b_re || b_we |=> ##1 $stable(b_dout))
        else $error("b moved");
    a_read_a: assert property (a_re && !a_we |=> ##1 a_dout == $past(ea_q))
        else $error("a data");
    b_read_a: assert property (b_re && !b_we |=> ##1 b_dout == $past(eb_q))
        else $error("b data");
    rst_zero_a: assert property ($rose(rst_n) |-> a_dout == 9'h0)
        else $error("a not zero");
    in_clr_a: assert property (disable iff (!LIVE || !rst_n || !out_clr_n)
        !in_clr_n |=> ##1 $stable(a_dout))
        else $error("a moved in clear");
endmodule // erb_chk
// Shadow models registered dual-port timing; bypassed copies are left to the bench
bind erb_ram erb_chk #(.LIVE(OUT_REG != 0 && FLOW == 0)) chk (.mclk(mclk), .rst_n(rst_n),
    .in_clr_n(in_clr_n),
    .out_clr_n(out_clr_n), .a_addr(a_addr), .a_din(a_din), .a_dout(a_dout), .a_we(a_we),
    .a_re(a_re), .b_addr(b_addr), .b_din(b_din), .b_dout(b_dout), .b_we(b_we), .b_re(b_re));

/* File: testbench/erb_fab.sv */
`timescale 1ns/1ns
module erb_fab (
    // Clock
    input wire mclk,
    // Port B requests
    output logic [7:0] b_addr = 8'h0,
    output logic [17:0] b_din = 18'h0,
    output logic b_we = 1'b0,
    output logic b_re = 1'b0
);
    // One writer per unit per edge
    task wr(input [7:0] ad, input [17:0] d);
        b_addr = ad;
        b_din = d;
        b_we = 1'b1;
        @(posedge mclk);
        #1 b_we = 1'b0; // Enable stays low once written
        b_din = ~d;
    endtask
    // Read; answer settled after the second edge
    task rd(input [7:0] ad);
        b_addr = ad;
        b_re = 1'b1;
        @(posedge mclk);
        #1 b_re = 1'b0;
        @(posedge mclk);
        #1;
    endtask
endmodule // erb_fab

/* File: testbench/tb_top.sv */
`timescale 1ns/1ns
module tb_top;
    logic mclk, rst_n, in_clr_n, out_clr_n, a_we, a_re;
    logic [8:0] a_addr, a_din;
    wire [8:0] a_dout;
    wire [7:0] b_addr;
    wire [17:0] b_din, b_dout, fl_dout;
    wire b_we, b_re;
    int bad_count, comparisons, cyc;
    // Port B word is two units of the same array
    erb_ram #(.RB(2)) dut (.mclk(mclk), .rst_n(rst_n), .in_clr_n(in_clr_n),
        .out_clr_n(out_clr_n), .a_addr(a_addr), .a_din(a_din), .a_we(a_we), .a_re(a_re),
        .a_dout(a_dout), .b_addr(b_addr), .b_din(b_din), .b_we(b_we), .b_re(b_re),
        .b_dout(b_dout));
    erb_fab fb (.mclk(mclk), .b_addr(b_addr), .b_din(b_din), .b_we(b_we), .b_re(b_re));
    // Simple dual-port copy with flow-through reads; A writes, B reads through the bypass
    erb_ram #(.MODE(1), .RB(2), .OUT_REG(0), .FLOW(1)) dut_fl (.mclk(mclk), .rst_n(rst_n),
        .in_clr_n(in_clr_n), .out_clr_n(out_clr_n), .a_addr(a_addr), .a_din(a_din),
        .a_we(a_we), .a_re(a_re), .a_dout(), .b_addr(b_addr), .b_din(b_din), .b_we(b_we),
        .b_re(b_re), .b_dout(fl_dout));
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    task chk(input string w, input logic [17:0] s, e);
        comparisons++;
        if (s !== e) begin
            bad_count++;
            $display("wrong value %s exp %h seen %h", w, e, s);
        end
    endtask
    task test_done;
        $display("checks %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // Hang guard; tests need under 100 cycles
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 2000) begin
            bad_count++;
            test_done;
        end
    end
    // Write; caller drops the enable after the last one
    task aw(input [8:0] ad, d);
        a_addr = ad;
        a_din = d;
        a_we = 1'b1;
        @(posedge mclk);
        #1;
    endtask
    task ar(input [8:0] ad, e);
        a_addr = ad;
        a_re = 1'b1;
        @(posedge mclk);
        #1 a_re = 1'b0;
        @(posedge mclk);
        #1 chk("a_dout", {9'h0, a_dout}, {9'h0, e});
    endtask
    // Back-to-back unit writes, read as wide words
    task t_mixed;
        for (int i = 0; i < 4; i++)
            aw(9'(i), 9'h100 | 9'(i * 17));
        a_we = 1'b0;
        fb.rd(8'h0);
        chk("b_dout", b_dout, {9'h111, 9'h100});
        chk("fl_dout", fl_dout, {9'h111, 9'h100});
        // Flow-through data is there after the falling edge, a cycle and a half before registered data
        fork
            fb.rd(8'h1);
            #5 chk("fl_dout", fl_dout, {9'h133, 9'h122});
        join
        chk("b_dout", b_dout, {9'h133, 9'h122});
        ar(9'h2, 9'h122);
        $display("t_mixed end");
    endtask
    // Wide write read narrow; same-edge write and read
    task t_cross;
        fb.wr(8'h5, 18'h2a5c3);
        ar(9'ha, 9'h1c3);
        ar(9'hb, 9'h152);
        // Enable drops after its one edge so the write is not repeated
        fork
            begin
                aw(9'h14, 9'h0aa);
                a_we = 1'b0;
            end
            fb.rd(8'h1);
        join
        chk("b_dout", b_dout, {9'h133, 9'h122});
        ar(9'h14, 9'h0aa);
        $display("t_cross end");
    endtask
    task t_clr;
        ar(9'h0, 9'h100);
        in_clr_n = 1'b0;
        #1 chk("a_dout", {9'h0, a_dout}, 18'h100);
        @(posedge mclk);
        #1 in_clr_n = 1'b1;
        out_clr_n = 1'b0;
        #1 chk("b_dout", b_dout, 18'h0);
        chk("a_dout", {9'h0, a_dout}, 18'h0);
        @(posedge mclk);
        #1 out_clr_n = 1'b1;
        ar(9'h1, 9'h111);
        $display("t_clr end");
    endtask
    initial begin
        {rst_n, a_we, a_re, a_addr, a_din} = '0;
        {in_clr_n, out_clr_n} = 2'h3;
        repeat (10) @(posedge mclk);
        #1 rst_n = 1'b1;
        t_mixed;
        t_cross;
        t_clr;
        test_done;
    end
endmodule // tb_top
